// ### hw/gpp_port.v
// General purpose pin port: direction, level, input, pin config, flags
// ----------------------------------------
// How it works
// - Drive-enable bit one turns pin driver on; zero makes pin an input.
// - Drive-enable set strobe sets only the written one bits.
// - Drive-enable clear strobe clears only the written one bits.
// - Drive-enable toggle strobe inverts only the written one bits.
// - Level set strobe forces written one bits of output level high.
// - Level clear strobe forces written one bits of output level low.
// - Writing ones to level toggle or input value inverts output level bits.
// - Input value shows synchronized pin level whether input or output.
// - Input-disabled sense setting stops the synchronizer; value is not valid.
// - After reset drivers are off and input buffers enabled.
// - Pin n configuration sits at offset 0x10 plus n.
// - Alias registers behave exactly like the regular ones when written.
// - Inversion bit inverts both input and output paths of the pin.
// - Toggling inversion makes an edge seen by users, events and interrupts.
// - Pull-up bit one enables the pin's pull-up resistor.
// - Sense field picks any edge, rising, falling, low level or input off.
// - Inversion toggled with sense write may produce no interrupt.
// - Event pending while input disabled may fire on re-enable.
// - Event in flight when sense changes may be dropped.
// - Async pins wake on any sense; others only any-edge or level.
// - Asynchronous sensing lets a pin change wake from every sleep mode.
// - Debug mode does not change port behaviour.
// - Event output is pin value when input on, else zero.
// - Flag sets on sense condition while enabled; request holds while any flag is set.
// - Three dead cycles after an interrupt; pulses need one clock.
// ----------------------------------------
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "gpp_defs.vh"

module gpp_port
#(
   parameter WIDTH = 8
)
(
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Register port
   input wire [5:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Pads
   input wire [WIDTH-1:0] pad_in,
   output wire [WIDTH-1:0] pad_out,
   output wire [WIDTH-1:0] pad_oe_n,
   output wire [WIDTH-1:0] pad_pullup,
   output wire [WIDTH-1:0] pad_input_en,
   // System side
   input wire sleeping,
   output wire [WIDTH-1:0] pin_event,
   output wire [WIDTH-1:0] pin_value,
   output wire irq,
   output wire wake
);

   reg [WIDTH-1:0] drive_en_ff;
   reg [WIDTH-1:0] nxt_drive_en;
   reg [WIDTH-1:0] level_ff;
   reg [WIDTH-1:0] nxt_level;
   reg [WIDTH-1:0] flags_ff;
   reg [WIDTH-1:0] nxt_flags;
   reg [WIDTH-1:0] async_mask_ff;
   reg [7:0] cfg_ff [0:WIDTH-1];
   reg [7:0] nxt_rdata;
   wire [WIDTH-1:0] sync_in;
   wire [WIDTH-1:0] detect;
   wire [WIDTH-1:0] wake_hit;
   wire [WIDTH-1:0] irq_en;
   wire [WIDTH-1:0] wake_ok;
   wire [WIDTH-1:0] wr_cfg;
   wire [5:0] eff_addr;
   wire [WIDTH-1:0] wbits;

   assign wbits = reg_wdata[WIDTH-1:0];

   // ----------------------------------------
   // Alias window folds onto regular offsets
   // ----------------------------------------
   // Aliases cover direction, level, input value and flags only
   assign eff_addr = ((reg_addr & 6'h3c) == `GPP_ALIAS_BASE) ?
      ((reg_addr[1:0] == 2'h0) ? `GPP_DRIVE_ENABLE :
       (reg_addr[1:0] == 2'h1) ? `GPP_LEVEL :
       (reg_addr[1:0] == 2'h2) ? `GPP_INPUT_VALUE : `GPP_PIN_IRQ_FLAGS) : reg_addr;

   // ----------------------------------------
   // Direction register
   // ----------------------------------------
   always @*
   begin
      nxt_drive_en = drive_en_ff;
      if (reg_wr)
      begin
         case (eff_addr)
            `GPP_DRIVE_ENABLE: nxt_drive_en = wbits;
            `GPP_DRIVE_ENABLE_SET: nxt_drive_en = drive_en_ff | wbits;
            `GPP_DRIVE_ENABLE_CLR: nxt_drive_en = drive_en_ff & ~wbits;
            `GPP_DRIVE_ENABLE_TGL: nxt_drive_en = drive_en_ff ^ wbits;
            default: nxt_drive_en = drive_en_ff;
         endcase
      end
   end

   // ----------------------------------------
   // Output level register
   // ----------------------------------------
   always @*
   begin
      nxt_level = level_ff;
      if (reg_wr)
      begin
         case (eff_addr)
            `GPP_LEVEL: nxt_level = wbits;
            `GPP_LEVEL_SET: nxt_level = level_ff | wbits;
            `GPP_LEVEL_CLR: nxt_level = level_ff & ~wbits;
            `GPP_LEVEL_TGL: nxt_level = level_ff ^ wbits;
            `GPP_INPUT_VALUE: nxt_level = level_ff ^ wbits;
            default: nxt_level = level_ff;
         endcase
      end
   end

   // ----------------------------------------
   // Interrupt flags, set wins over clear
   // ----------------------------------------
   always @*
   begin
      nxt_flags = flags_ff;
      if (reg_wr && eff_addr == `GPP_PIN_IRQ_FLAGS)
         nxt_flags = flags_ff & ~wbits;
      nxt_flags = nxt_flags | (detect & irq_en);
   end

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         drive_en_ff <= {WIDTH{1'b0}};
         level_ff <= {WIDTH{1'b0}};
         flags_ff <= {WIDTH{1'b0}};
         async_mask_ff <= {WIDTH{1'b0}};
      end
      else
      begin
         drive_en_ff <= nxt_drive_en;
         level_ff <= nxt_level;
         flags_ff <= nxt_flags;
         if (reg_wr && reg_addr == `GPP_WAKE_ASYNC_MASK)
            async_mask_ff <= wbits;
      end
   end

   // ----------------------------------------
   // Per-pin configuration and sensing
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1)
      begin : g_pin
         localparam [5:0] PIN_OFS = gi;
         wire inv;
         wire [2:0] sense;
         assign inv = cfg_ff[gi][`GPP_CFG_INV_BIT];
         assign sense = cfg_ff[gi][`GPP_CFG_SENSE_MSB:`GPP_CFG_SENSE_LSB];
         assign wr_cfg[gi] = reg_wr && (reg_addr == `GPP_PIN_CFG_BASE + PIN_OFS);

         always @(posedge core_clk)
         begin
            if (srst)
               cfg_ff[gi] <= `GPP_RST_BYTE;
            else if (wr_cfg[gi])
               cfg_ff[gi] <= reg_wdata;
         end

         // Inversion sits before the synchronizer, so a toggle is a real edge
         gpp_pin_sense u_sense
         (
            .core_clk(core_clk),
            .srst(srst),
            .pin_level(pad_in[gi] ^ inv),
            .sense_sel(sense),
            .cfg_wr(wr_cfg[gi]),
            .sync_level(sync_in[gi]),
            .detect(detect[gi]),
            .wake_req(wake_hit[gi])
         );

         assign pad_out[gi] = level_ff[gi] ^ inv;
         assign pad_oe_n[gi] = ~drive_en_ff[gi];
         assign pad_pullup[gi] = cfg_ff[gi][`GPP_CFG_PULL_BIT];
         assign pad_input_en[gi] = (sense != `GPP_SENSE_INPUT_OFF);
         assign pin_value[gi] = sync_in[gi];
         assign pin_event[gi] = pad_input_en[gi] & (pad_in[gi] ^ inv);
         assign irq_en[gi] = (sense != `GPP_SENSE_INTDISABLE) && (sense != `GPP_SENSE_INPUT_OFF);
         // Clocked model: single edges on ordinary pins cannot wake from a stopped clock
         assign wake_ok[gi] = async_mask_ff[gi] ||
            (sense == `GPP_SENSE_ANY_EDGE) || (sense == `GPP_SENSE_LOW_LEVEL);
      end
   endgenerate

   assign irq = |flags_ff;
   assign wake = sleeping & |(wake_hit & irq_en & wake_ok);

   // ----------------------------------------
   // Read path, data one cycle after strobe
   // ----------------------------------------
   // No debug input exists, so debug cannot alter the port
   integer ri;
   always @*
   begin
      nxt_rdata = 8'h00;
      case (eff_addr)
         `GPP_DRIVE_ENABLE, `GPP_DRIVE_ENABLE_SET, `GPP_DRIVE_ENABLE_CLR, `GPP_DRIVE_ENABLE_TGL:
            nxt_rdata[WIDTH-1:0] = drive_en_ff;
         `GPP_LEVEL, `GPP_LEVEL_SET, `GPP_LEVEL_CLR, `GPP_LEVEL_TGL:
            nxt_rdata[WIDTH-1:0] = level_ff;
         `GPP_INPUT_VALUE: nxt_rdata[WIDTH-1:0] = sync_in;
         `GPP_PIN_IRQ_FLAGS: nxt_rdata[WIDTH-1:0] = flags_ff;
         `GPP_WAKE_ASYNC_MASK: nxt_rdata[WIDTH-1:0] = async_mask_ff;
         default:
         begin
            for (ri = 0; ri < WIDTH; ri = ri + 1)
               if (reg_addr == `GPP_PIN_CFG_BASE + ri[5:0])
                  nxt_rdata = cfg_ff[ri];
         end
      endcase
   end

   always @(posedge core_clk)
   begin
      if (srst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= nxt_rdata;
      else
         reg_rdata <= 8'h00;
   end

endmodule // gpp_port

// ### hw/gpp_defs.vh
// Offsets, field positions, reset values and timing counts of the pin port
`ifndef GPP_DEFS_VH
`define GPP_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GPP_DRIVE_ENABLE      6'h00
`define GPP_DRIVE_ENABLE_SET  6'h01
`define GPP_DRIVE_ENABLE_CLR  6'h02
`define GPP_DRIVE_ENABLE_TGL  6'h03
`define GPP_LEVEL             6'h04
`define GPP_LEVEL_SET         6'h05
`define GPP_LEVEL_CLR         6'h06
`define GPP_LEVEL_TGL         6'h07
`define GPP_INPUT_VALUE       6'h08
`define GPP_PIN_IRQ_FLAGS     6'h09
`define GPP_PIN_CFG_BASE      6'h10
`define GPP_ALIAS_BASE        6'h20
`define GPP_WAKE_ASYNC_MASK   6'h28

// ----------------------------------------
// Per-pin configuration fields
// ----------------------------------------
`define GPP_CFG_INV_BIT       7
`define GPP_CFG_PULL_BIT      3
`define GPP_CFG_SENSE_MSB     2
`define GPP_CFG_SENSE_LSB     0

// ----------------------------------------
// Input sense encodings
// ----------------------------------------
`define GPP_SENSE_INTDISABLE  3'h0
`define GPP_SENSE_ANY_EDGE    3'h1
`define GPP_SENSE_RISING      3'h2
`define GPP_SENSE_FALLING     3'h3
`define GPP_SENSE_INPUT_OFF   3'h4
`define GPP_SENSE_LOW_LEVEL   3'h5

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define GPP_RST_BYTE          8'h00
`define GPP_DEAD_CYCLES       2'h3

`endif

// ### hw/gpp_pin_sense.v
// One pin's synchronizer, edge and level sensing with interrupt dead time
`include "gpp_defs.vh"

module gpp_pin_sense
(
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Pin side, already inverted where configured
   input wire pin_level,
   // Configuration
   input wire [2:0] sense_sel,
   input wire cfg_wr,
   // Results
   output wire sync_level,
   output wire detect,
   output wire wake_req
);

   reg sync1_ff;
   reg sync2_ff;
   reg prev_ff;
   reg [1:0] dead_ff;
   reg [1:0] nxt_dead;
   reg hit;
   wire input_on;

   assign input_on = (sense_sel != `GPP_SENSE_INPUT_OFF);

   // ----------------------------------------
   // Synchronizer, halted while input is off
   // ----------------------------------------
   // Halting leaves old state in prev_ff, so a pending edge may fire on re-enable
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff <= 1'b0;
      end
      else if (input_on)
      begin
         sync1_ff <= pin_level;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   assign sync_level = sync2_ff;

   // ----------------------------------------
   // Sense condition
   // ----------------------------------------
   always @*
   begin
      case (sense_sel)
         `GPP_SENSE_ANY_EDGE: hit = sync2_ff ^ prev_ff;
         `GPP_SENSE_RISING: hit = sync2_ff & ~prev_ff;
         `GPP_SENSE_FALLING: hit = ~sync2_ff & prev_ff;
         `GPP_SENSE_LOW_LEVEL: hit = ~sync2_ff;
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Dead time after each accepted event
   // ----------------------------------------
   always @*
   begin
      nxt_dead = dead_ff;
      if (detect)
         nxt_dead = `GPP_DEAD_CYCLES;
      else if (dead_ff != 2'h0)
         nxt_dead = dead_ff - 2'h1;
   end

   always @(posedge core_clk)
   begin
      if (srst)
         dead_ff <= 2'h0;
      else
         dead_ff <= nxt_dead;
   end

   // A write to the configuration drops the event in flight
   assign detect = hit & input_on & ~cfg_wr & (dead_ff == 2'h0);

   assign wake_req = hit & input_on;

endmodule // gpp_pin_sense

// ### verification/gpp_port_asserts.sv
// Checker of register-to-pad relations of the pin port
module gpp_port_chk
#(
   parameter WIDTH = 8
)
(
   // Clock and reset
   input logic core_clk,
   input logic srst,
   // Register port
   input logic [5:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   // Pads and system
   input logic [WIDTH-1:0] pad_out,
   input logic [WIDTH-1:0] pad_oe_n,
   input logic [WIDTH-1:0] pad_pullup,
   input logic [WIDTH-1:0] pad_input_en,
   input logic [WIDTH-1:0] pin_event,
   input logic sleeping,
   input logic irq,
   input logic wake
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   AST_RST_PADS: assert property ($fell(srst) |-> &pad_oe_n && &pad_input_en && pad_pullup == 0 && !irq)
      else $error("pads not idle after reset");
   AST_DRV_WR: assert property (reg_wr && reg_addr == 6'h00 |=> pad_oe_n == ~$past(reg_wdata[WIDTH-1:0]))
      else $error("drive write");
   AST_DRV_SET: assert property (reg_wr && reg_addr == 6'h01 |=>
      pad_oe_n == ($past(pad_oe_n) & ~$past(reg_wdata[WIDTH-1:0])))
      else $error("drive set");
   AST_DRV_CLR: assert property (reg_wr && reg_addr == 6'h02 |=>
      pad_oe_n == ($past(pad_oe_n) | $past(reg_wdata[WIDTH-1:0])))
      else $error("drive clear");
   AST_DRV_TGL: assert property (reg_wr && reg_addr == 6'h03 |=>
      pad_oe_n == ($past(pad_oe_n) ^ $past(reg_wdata[WIDTH-1:0])))
      else $error("drive toggle");
   AST_LVL_TGL: assert property (reg_wr && (reg_addr == 6'h07 || reg_addr == 6'h08) |=>
      pad_out == ($past(pad_out) ^ $past(reg_wdata[WIDTH-1:0])))
      else $error("level toggle");
   AST_DRV_HOLD: assert property (!reg_wr |=> $stable(pad_oe_n))
      else $error("drive moved without write");
   AST_DRV_READ: assert property (reg_rd && reg_addr == 6'h00 |=> reg_rdata[WIDTH-1:0] == ~$past(pad_oe_n))
      else $error("drive readback");
   AST_EVT_OFF: assert property ((pin_event & ~pad_input_en) == 0)
      else $error("event from disabled input");
   AST_WAKE_IDLE: assert property (!sleeping |-> !wake)
      else $error("wake while awake");
endmodule // gpp_port_chk

bind gpp_port gpp_port_chk #(.WIDTH(WIDTH)) gpp_port_chk_inst (.core_clk(core_clk), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup), .pad_input_en(pad_input_en),
   .pin_event(pin_event), .sleeping(sleeping), .irq(irq), .wake(wake));

// ### verification/gpp_pad_model.sv
// Pad model: wire level from port drive, far-side drive and pull-up
module gpp_pad_model
#(
   parameter WIDTH = 8
)
(
   // Clock
   input logic core_clk,
   // Port side
   input logic [WIDTH-1:0] pad_out,
   input logic [WIDTH-1:0] pad_oe_n,
   input logic [WIDTH-1:0] pad_pullup,
   // Far side
   input logic [WIDTH-1:0] ext_level,
   input logic [WIDTH-1:0] ext_en,
   // Wire level
   output logic [WIDTH-1:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [WIDTH-1:0] float_ff = '0;
   // Floating lines wander so a stale level is never mistaken for a real one
   always @(posedge core_clk)
   begin
      float_ff <= ~pad_in;
   end
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_level)
      | (pad_oe_n & ~ext_en & (pad_pullup | float_ff));
endmodule // gpp_pad_model

// ### verification/gpp_port_tb.sv
// Self-checking bench of the pin port
module gpp_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WIDTH = 8;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sleeping = 1'b0;
   logic [7:0] reg_rdata, rd_val;
   logic [WIDTH-1:0] pad_in, pad_out, pad_oe_n, pad_pullup, pad_input_en, pin_event, pin_value;
   logic [WIDTH-1:0] ext_level = 8'h00;
   logic [WIDTH-1:0] ext_en = 8'hff;
   logic irq, wake;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int wake_cnt = 0;
   int n_wake = 0;
   // Write address, write data, read address, expected read data
   logic [27:0] rows [13] = '{{6'h00, 8'h0f, 6'h00, 8'h0f}, {6'h01, 8'h30, 6'h00, 8'h3f},
      {6'h02, 8'h05, 6'h01, 8'h3a}, {6'h03, 8'hff, 6'h03, 8'hc5}, {6'h04, 8'h0f, 6'h04, 8'h0f},
      {6'h05, 8'h30, 6'h04, 8'h3f}, {6'h06, 8'h05, 6'h04, 8'h3a}, {6'h07, 8'h81, 6'h04, 8'hbb},
      {6'h08, 8'h03, 6'h04, 8'hb8}, {6'h20, 8'h11, 6'h00, 8'h11}, {6'h21, 8'h22, 6'h04, 8'h22},
      {6'h3f, 8'hff, 6'h3f, 8'h00}, {6'h10, 8'h88, 6'h10, 8'h88}};
   logic [2:0] senses [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
   logic [7:0] fall_exp [4] = '{8'h04, 8'h00, 8'h04, 8'h04};
   logic [7:0] rise_exp [4] = '{8'h04, 8'h04, 8'h00, 8'h00};

   gpp_port #(.WIDTH(WIDTH)) gpp_port_inst (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup), .pad_input_en(pad_input_en),
      .sleeping(sleeping), .pin_event(pin_event), .pin_value(pin_value), .irq(irq), .wake(wake));
   gpp_pad_model #(.WIDTH(WIDTH)) pads (.core_clk(core_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pullup(pad_pullup), .ext_level(ext_level), .ext_en(ext_en), .pad_in(pad_in));

   // ----------------------------------------
   // Bus cycles, compare and verdict
   // ----------------------------------------
   task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic bus_rd(input logic [5:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      forever #20 core_clk = ~core_clk;
   end
   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge core_clk)
   begin
      cycles++;
      // Wake is a one-cycle pulse for edges, so count it where it stands
      if (wake === 1'b1)
         wake_cnt++;
      if (cycles == 3000)
      begin
         err_count++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("oe_n", 8'hff, pad_oe_n);
      chk("input_en", 8'hff, pad_input_en);
      @(posedge core_clk);
      for (int i = 0; i < 13; i++)
      begin
         bus_wr(rows[i][27:22], rows[i][21:14]);
         bus_rd(rows[i][13:8]);
         chk("row", rows[i][7:0], rd_val);
      end
      chk("pullup", 8'h01, pad_pullup);
      chk("pad_out", 8'h23, pad_out);
      ext_level <= 8'ha5;
      repeat (4) @(posedge core_clk);
      bus_rd(6'h08);
      chk("input_value", 8'ha4, rd_val);
      chk("pin_value", 8'ha4, pin_value);
      bus_wr(6'h12, 8'h04);
      chk("input_en", 8'hfb, pad_input_en);
      chk("event", 8'ha0, pin_event);
      foreach (senses[k])
      begin
         ext_level <= 8'h04;
         bus_wr(6'h12, {5'h00, senses[k]});
         repeat (6) @(posedge core_clk);
         bus_wr(6'h09, 8'hff);
         ext_level <= 8'h00;
         repeat (6) @(posedge core_clk);
         bus_rd(6'h09);
         chk("fall_flag", fall_exp[k], rd_val);
         chk("irq", {7'h00, fall_exp[k][2]}, {7'h00, irq});
         if (k < 3)
         begin
            bus_wr(6'h09, 8'hff);
            bus_rd(6'h09);
            chk("cleared", 8'h00, rd_val);
            ext_level <= 8'h04;
            repeat (6) @(posedge core_clk);
            bus_rd(6'h09);
            chk("rise_flag", rise_exp[k], rd_val);
         end
      end
      // Pin 2 is low with low-level sensing here
      sleeping <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("wake_level", 8'h01, {7'h00, wake});
      bus_wr(6'h12, 8'h02);
      n_wake = wake_cnt;
      ext_level <= 8'h04;
      repeat (6) @(posedge core_clk);
      chk("wake_rise", 8'h00, 8'(wake_cnt - n_wake));
      bus_wr(6'h28, 8'h04);
      ext_level <= 8'h00;
      repeat (4) @(posedge core_clk);
      n_wake = wake_cnt;
      ext_level <= 8'h04;
      repeat (6) @(posedge core_clk);
      chk("wake_async", 8'h01, 8'(wake_cnt - n_wake));
      sleeping <= 1'b0;
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("oe_n", 8'hff, pad_oe_n);
      chk("pullup", 8'h00, pad_pullup);
      chk("irq", 8'h00, {7'h00, irq});
      give_verdict();
   end
endmodule // gpp_port_tb
